// ---- logic/crf_formatter.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "crf_map.svh"
module crf_formatter (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  input  wire logic                event_a_in,
  input  wire logic                event_b_in,
  input  wire logic                event_c_in,
  input  wire logic                timebase_in,
  input  wire logic                gate_open,
  input  wire crf_pkg::crf_func_t  meas_func,
  input  wire logic [7:0]          start_interp_count,
  input  wire logic [7:0]          stop_interp_count,
  input  wire logic                fast_raw_output_on,
  input  wire logic                fast_raw_output_off,
  input  wire logic                total_start_function,
  input  wire logic                total_stop_function,
  input  wire logic                ext_arm_en,
  input  wire logic                stop_arm,
  input  wire logic                talk_only,
  input  wire logic                cal_data_request,
  input  wire logic [47:0]         cal_digits,
  input  wire logic                meas_done,
  input  wire crf_pkg::crf_rtype_t res_type,
  input  wire logic                res_neg,
  input  wire logic [43:0]         res_mant,
  input  wire logic [3:0]          res_ndig,
  input  wire logic                res_exp_neg,
  input  wire logic [7:0]          res_exp,
  input  wire logic                res_zero,
  input  wire logic                res_overflow,
  input  wire logic                res_peak,
  input  wire logic                out_ready,
  output logic                     out_valid,
  output logic [7:0]               out_data_ff,
  output logic                     out_eoi_ff,
  output logic                     busy
);
  // ==========================================================
  // pin synchronisers
  logic [3:0] pin_raw;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;
  logic [3:0] pin_rise;
  assign pin_raw = {timebase_in, event_c_in, event_b_in, event_a_in};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_ff[g] <= 1'b0;
          sync2_ff[g] <= 1'b0;
          sync3_ff[g] <= 1'b0;
        end else if (clk_en) begin
          sync1_ff[g] <= pin_raw[g];
          sync2_ff[g] <= sync1_ff[g];
          sync3_ff[g] <= sync2_ff[g];
        end
      end
      assign pin_rise[g] = sync2_ff[g] & ~sync3_ff[g];
    end
  endgenerate

  // ==========================================================
  // fast mode and totalize control
  logic hs_ff;
  logic hs_func;
  logic hs_act;
  logic tot_run_ff;
  logic fin_pend_ff;
  logic tot_stop_ev;
  logic fin_take;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) hs_ff <= 1'b0;
    else if (clk_en) begin
      if (fast_raw_output_on) hs_ff <= 1'b1;
      else if (fast_raw_output_off) hs_ff <= 1'b0;
    end
  end
  assign hs_func = (meas_func == crf_pkg::FN_FREQ_A) ||
                   (meas_func == crf_pkg::FN_FREQ_B) ||
                   (meas_func == crf_pkg::FN_THIRD_CHANNEL_FREQUENCY) ||
                   (meas_func == crf_pkg::FN_PERIOD) ||
                   (meas_func == crf_pkg::FN_TI) ||
                   (meas_func == crf_pkg::FN_RATIO);
  assign hs_act = hs_ff & hs_func;
  assign tot_stop_ev = tot_run_ff &
                       (ext_arm_en ? stop_arm : total_stop_function);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tot_run_ff <= 1'b0;
    else if (clk_en) begin
      if (total_start_function) tot_run_ff <= 1'b1;
      else if (tot_stop_ev) tot_run_ff <= 1'b0;
    end
  end
  // set wins over the load that clears it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) fin_pend_ff <= 1'b0;
    else if (clk_en) begin
      if (tot_stop_ev) fin_pend_ff <= 1'b1;
      else if (fin_take) fin_pend_ff <= 1'b0;
    end
  end

  // ==========================================================
  // event and time counters
  function automatic logic [23:0] bcd_inc(input logic [23:0] v);
    logic [23:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    if (v[23:20] != `CRF_BCD_OVF) begin
      for (int i = 0; i < 5; i++) begin
        if (c) begin
          if (r[i*4 +: 4] == 4'h9) r[i*4 +: 4] = 4'h0;
          else begin
            r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
            c = 1'b0;
          end
        end
      end
      if (c) r[23:20] = (r[23:20] == 4'h9) ? `CRF_BCD_OVF
                                           : r[23:20] + 4'h1;
    end
    return r;
  endfunction : bcd_inc

  logic [23:0] ev_ff;
  logic [23:0] tm_ff;
  logic [4:0]  pre_ff;
  logic        gate_d_ff;
  logic        gate_rise;
  logic        gate_fall;
  logic        counting;
  logic        ev_pulse;
  logic        tm_pulse;
  logic        c_tick;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) gate_d_ff <= 1'b0;
    else if (clk_en) gate_d_ff <= gate_open;
  end
  assign gate_rise = gate_open & ~gate_d_ff;
  assign gate_fall = ~gate_open & gate_d_ff;
  assign counting = (meas_func == crf_pkg::FN_TOTAL) ? tot_run_ff : gate_open;
  assign c_tick = pin_rise[2] && (pre_ff == `CRF_PRESCALE_C - 5'h1);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) pre_ff <= 5'h00;
    else if (clk_en) begin
      if (gate_rise) pre_ff <= 5'h00;
      else if (pin_rise[2]) pre_ff <= c_tick ? 5'h00 : pre_ff + 5'h01;
    end
  end
  always_comb begin
    unique case (meas_func)
      crf_pkg::FN_RATIO: begin
        ev_pulse = pin_rise[1];
        tm_pulse = pin_rise[0];
      end
      crf_pkg::FN_THIRD_CHANNEL_FREQUENCY: begin
        ev_pulse = c_tick;
        tm_pulse = pin_rise[3];
      end
      default: begin
        ev_pulse = pin_rise[0];
        tm_pulse = pin_rise[3];
      end
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_ff <= 24'h000000;
      tm_ff <= 24'h000000;
    end else if (clk_en) begin
      if (gate_rise || total_start_function) begin
        ev_ff <= 24'h000000;
        tm_ff <= 24'h000000;
      end else if (counting) begin
        if (ev_pulse) ev_ff <= bcd_inc(ev_ff);
        if (tm_pulse) tm_ff <= bcd_inc(tm_ff);
      end
    end
  end

  // ==========================================================
  // request arbitration
  crf_pkg::crf_state_t state_ff;
  crf_pkg::crf_kind_t  kind_ff;
  crf_pkg::crf_kind_t  nxt_kind;
  logic       load;
  logic       want_norm;
  logic       ovf_ok;
  logic [7:0] letter;
  logic [4:0] len_ff;
  logic [4:0] idx_ff;
  logic [4:0] nxt_len;
  logic       beat;
  logic       last_beat;
  assign ovf_ok = res_overflow && (res_type != crf_pkg::RT_TRIG_A) &&
                  (res_type != crf_pkg::RT_TRIG_B);
  assign want_norm = meas_done && !hs_act &&
                     !((meas_func == crf_pkg::FN_TOTAL) &&
                       (!tot_run_ff || talk_only));
  assign fin_take = (state_ff == crf_pkg::ST_IDLE) && !cal_data_request &&
                    !(hs_act && gate_fall) && fin_pend_ff;
  always_comb begin
    load = state_ff == crf_pkg::ST_IDLE;
    nxt_kind = crf_pkg::KD_NORMAL;
    if (cal_data_request) nxt_kind = crf_pkg::KD_CAL;
    else if (hs_act && gate_fall) nxt_kind = crf_pkg::KD_HS;
    else if (fin_pend_ff) nxt_kind = crf_pkg::KD_NORMAL;
    else if (want_norm && ovf_ok)
      nxt_kind = res_peak ? crf_pkg::KD_PEAK : crf_pkg::KD_OVER;
    else if (!want_norm) load = 1'b0;
  end
  always_comb begin
    unique case (fin_pend_ff ? crf_pkg::RT_TOT_FINAL :
                 (meas_func == crf_pkg::FN_TOTAL) ?
                 crf_pkg::RT_TOT_INTERIM : res_type)
      crf_pkg::RT_FREQ:        letter = `CRF_CH_F;
      crf_pkg::RT_TIME:        letter = `CRF_CH_S;
      crf_pkg::RT_VOLT:        letter = `CRF_CH_V;
      crf_pkg::RT_RATIO:       letter = `CRF_CH_R;
      crf_pkg::RT_TOT_FINAL:   letter = `CRF_CH_TU;
      crf_pkg::RT_TOT_INTERIM: letter = `CRF_CH_TL;
      crf_pkg::RT_TRIG_A:      letter = `CRF_CH_A;
      crf_pkg::RT_TRIG_B:      letter = `CRF_CH_B;
      crf_pkg::RT_PEAK_HI:     letter = `CRF_CH_H;
      crf_pkg::RT_PEAK_LO:     letter = `CRF_CH_L;
      crf_pkg::RT_OVER:        letter = `CRF_CH_O;
      default:                 letter = `CRF_CH_C;
    endcase
  end

  // ==========================================================
  // record builder
  logic [7:0]  buf_ff  [0:`CRF_BUF_BYTES-1];
  logic [7:0]  nxt_buf [0:`CRF_BUF_BYTES-1];
  always_comb begin
    logic [43:0] m;
    logic [3:0]  d;
    logic        sgn_w;
    int          n;
    int          k;
    logic [7:0]  ex;
    logic        exn;
    m = res_mant;
    n = (res_ndig == 4'h0) ? 1 : (res_ndig > 4'hB) ? 11 : int'(res_ndig);
    sgn_w = !res_zero;
    ex = res_exp;
    exn = res_exp_neg;
    d = 4'h0;
    k = 0;
    nxt_len = `CRF_ASCII_LEN;
    for (int i = 0; i < `CRF_BUF_BYTES; i++) nxt_buf[i] = `CRF_CH_SP;
    if (res_zero) begin
      n = 1;
      m = 44'h0;
      ex = 8'h00;
      exn = 1'b0;
    end
    if (nxt_kind == crf_pkg::KD_OVER) begin
      n = `CRF_MANT_DIGITS;
      m = {11{4'h9}};
      sgn_w = 1'b1;
      ex = 8'h99;
      exn = 1'b0;
    end
    unique case (nxt_kind)
      crf_pkg::KD_HS: begin
        for (int i = 0; i < 3; i++) begin
          nxt_buf[i]   = ev_ff[16 - 8*i +: 8];
          nxt_buf[i+3] = tm_ff[16 - 8*i +: 8];
        end
        nxt_buf[6] = start_interp_count;
        nxt_buf[7] = stop_interp_count;
        nxt_len = `CRF_HS_LEN;
      end
      crf_pkg::KD_CAL: begin
        nxt_buf[0] = `CRF_CH_C;
        for (int i = 0; i < 12; i++)
          nxt_buf[2 + i + i/3] = `CRF_CH_ZERO + {4'h0, cal_digits[44-4*i +: 4]};
        for (int i = 0; i < 3; i++) nxt_buf[5 + 4*i] = `CRF_CH_COMMA;
        nxt_buf[17] = `CRF_CH_CR;
        nxt_buf[18] = `CRF_CH_LF;
        nxt_len = `CRF_CAL_LEN;
      end
      crf_pkg::KD_PEAK: begin
        for (int i = 0; i < 2; i++) begin
          nxt_buf[10*i]     = `CRF_CH_O;
          nxt_buf[10*i + 1] = `CRF_CH_PLUS;
          for (int j = 2; j < 9; j++) nxt_buf[10*i + j] = `CRF_CH_NINE;
        end
        nxt_buf[9]  = `CRF_CH_COMMA;
        nxt_buf[19] = `CRF_CH_CR;
        nxt_buf[20] = `CRF_CH_LF;
      end
      default: begin
        nxt_buf[0] = (nxt_kind == crf_pkg::KD_OVER) ? `CRF_CH_O : letter;
        for (int p = 1; p <= `CRF_FIELD_W; p++) begin
          k = p - (`CRF_POS_E - (int'(sgn_w) + n + ((n > 1) ? 1 : 0)));
          if (k >= 0) begin
            if (sgn_w && k == 0)
              nxt_buf[p] = res_neg && (nxt_kind != crf_pkg::KD_OVER) ?
                           `CRF_CH_MINUS : `CRF_CH_PLUS;
            else begin
              k = k - int'(sgn_w);
              if (k == 1) nxt_buf[p] = `CRF_CH_DOT;
              else begin
                if (k > 1) k = k - 1;
                d = m[40 - 4*k +: 4];
                nxt_buf[p] = `CRF_CH_ZERO + {4'h0, d};
              end
            end
          end
        end
        nxt_buf[15] = `CRF_CH_E;
        nxt_buf[16] = exn ? `CRF_CH_MINUS : `CRF_CH_PLUS;
        nxt_buf[17] = `CRF_CH_ZERO + {4'h0, ex[7:4]};
        nxt_buf[18] = `CRF_CH_ZERO + {4'h0, ex[3:0]};
        nxt_buf[19] = `CRF_CH_CR;
        nxt_buf[20] = `CRF_CH_LF;
      end
    endcase
  end

  // ==========================================================
  // byte sender
  assign out_valid = state_ff == crf_pkg::ST_SEND;
  assign busy      = out_valid;
  assign beat      = out_valid && out_ready;
  assign last_beat = beat && (idx_ff == len_ff - 5'h1);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) state_ff <= crf_pkg::ST_IDLE;
    else if (clk_en) begin
      unique case (state_ff)
        crf_pkg::ST_IDLE: if (load) state_ff <= crf_pkg::ST_SEND;
        crf_pkg::ST_SEND: if (last_beat) state_ff <= crf_pkg::ST_IDLE;
        default:          state_ff <= crf_pkg::ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `CRF_BUF_BYTES; i++) buf_ff[i] <= 8'h00;
      kind_ff <= crf_pkg::KD_NORMAL;
      len_ff  <= 5'h00;
    end else if (clk_en && load) begin
      for (int i = 0; i < `CRF_BUF_BYTES; i++) buf_ff[i] <= nxt_buf[i];
      kind_ff <= nxt_kind;
      len_ff  <= nxt_len;
    end
  end
  // data and eoi registered; eoi only with the final fast byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_ff      <= 5'h00;
      out_data_ff <= 8'h00;
      out_eoi_ff  <= 1'b0;
    end else if (clk_en) begin
      if (load) begin
        idx_ff      <= 5'h00;
        out_data_ff <= nxt_buf[0];
        out_eoi_ff  <= 1'b0;
      end else if (beat && !last_beat) begin
        idx_ff      <= idx_ff + 5'h1;
        out_data_ff <= buf_ff[idx_ff + 5'h1];
        out_eoi_ff  <= (kind_ff == crf_pkg::KD_HS) &&
                       (idx_ff + 5'h1 == `CRF_HS_LEN - 5'h1);
      end else if (last_beat) begin
        // eoi must not outlive the record
        out_eoi_ff  <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  // pending final loads next
  sequence s_fin_take;
    fin_take && clk_en;
  endsequence
  sequence s_fin_shown;
    out_valid && buf_ff[0] == `CRF_CH_TU;
  endsequence
  a_hs_eoi_last: assert property (
    @(posedge clk) disable iff (!reset_n)
    out_eoi_ff |-> out_valid && kind_ff == crf_pkg::KD_HS && idx_ff == 5'h7)
    else $error("eoi not on last fast byte");
  a_crlf_tail: assert property (
    @(posedge clk) disable iff (!reset_n)
    (beat && clk_en && kind_ff != crf_pkg::KD_HS && idx_ff == len_ff - 5'h2)
    |-> out_data_ff == `CRF_CH_CR)
    else $error("record tail not CR");
  a_ascii_len: assert property (
    @(posedge clk) disable iff (!reset_n)
    (load && clk_en && nxt_kind inside {crf_pkg::KD_NORMAL,
      crf_pkg::KD_OVER, crf_pkg::KD_PEAK}) |=> len_ff == `CRF_ASCII_LEN)
    else $error("ascii record length wrong");
  a_exp_letter: assert property (
    @(posedge clk) disable iff (!reset_n)
    (out_valid && (kind_ff == crf_pkg::KD_NORMAL ||
     kind_ff == crf_pkg::KD_OVER)) |-> buf_ff[`CRF_POS_E] == `CRF_CH_E)
    else $error("exponent letter missing");
  a_hs_len_eight: assert property (
    @(posedge clk) disable iff (!reset_n)
    (load && clk_en && nxt_kind == crf_pkg::KD_HS) |=>
    len_ff == `CRF_HS_LEN && buf_ff[0] == $past(ev_ff[23:16]) &&
    buf_ff[3] == $past(tm_ff[23:16]))
    else $error("fast packing wrong");
  a_talk_only: assert property (
    @(posedge clk) disable iff (!reset_n)
    (load && clk_en && talk_only && nxt_kind == crf_pkg::KD_NORMAL)
    |-> nxt_buf[0] != `CRF_CH_TL)
    else $error("interim record in talk-only");
  a_ovf_sticky: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ev_ff[23:20] == `CRF_BCD_OVF && !gate_rise && !total_start_function)
    |=> ev_ff[23:20] == `CRF_BCD_OVF)
    else $error("overflow digit lost");
  a_tot_frozen: assert property (
    @(posedge clk) disable iff (!reset_n)
    (meas_func == crf_pkg::FN_TOTAL && !tot_run_ff &&
     !total_start_function && !gate_rise) |=> $stable(ev_ff))
    else $error("events counted after stop");
  a_final_sent: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_fin_take |=> s_fin_shown)
    else $error("final count not loaded");
  a_hs_filter: assert property (
    @(posedge clk) disable iff (!reset_n)
    (load && nxt_kind == crf_pkg::KD_HS) |-> hs_func)
    else $error("fast record for wrong function");
endmodule : crf_formatter
`default_nettype wire

// ---- logic/crf_map.svh ----
// Functional notes
// - normal result: letter, pad, sign, digit, point, digits, exponent, CR LF
// - point is dropped when it would sit right before E
// - leading zero digit only for zero; zero sends 0E+00
// - record opens with one of twelve type letters
// - signed number right-justified in 14-character field, spaces before sign
// - exponent always E, sign and two decimal digits
// - every ascii record ends with CR then LF
// - plain overflow sends O +9.9999999999E+99 then CR LF
// - peak overflow sends two comma-joined O+9999999 fields; trigger never
// - interim t, final T; stop gives final and freezes counting
// - talk-only totalizing suppresses interim t records
// - with external arming, stop-arm produces the final T record
// - gate open: events count input, time counts 100 ns timebase
// - fast mode skips computation and streams raw counts
// - fast record is eight bytes, end-or-identify on the last
// - bytes 1-3 event BCD, 4-6 time BCD, 7 start, 8 stop interp
// - fast overflow shows top BCD digit of a counter as 1111
// - fast output only for frequency, period, interval and ratio
// - cal request sends C, space, four comma groups of three digits
// - ratio: B input to event counter, A input to time counter
// - third channel frequency events prescaled by 20
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH
// ==========================================================
// record geometry
`define CRF_BUF_BYTES   21
`define CRF_ASCII_LEN   5'h15
`define CRF_CAL_LEN     5'h13
`define CRF_HS_LEN      5'h08
`define CRF_FIELD_W     14
`define CRF_POS_E       15
`define CRF_MANT_DIGITS 11
`define CRF_PRESCALE_C  5'h14
// ==========================================================
// characters
`define CRF_CH_SP    8'h20
`define CRF_CH_PLUS  8'h2B
`define CRF_CH_MINUS 8'h2D
`define CRF_CH_DOT   8'h2E
`define CRF_CH_COMMA 8'h2C
`define CRF_CH_E     8'h45
`define CRF_CH_CR    8'h0D
`define CRF_CH_LF    8'h0A
`define CRF_CH_ZERO  8'h30
`define CRF_CH_NINE  8'h39
`define CRF_CH_F     8'h46
`define CRF_CH_S     8'h53
`define CRF_CH_V     8'h56
`define CRF_CH_R     8'h52
`define CRF_CH_TU    8'h54
`define CRF_CH_TL    8'h74
`define CRF_CH_A     8'h41
`define CRF_CH_B     8'h42
`define CRF_CH_H     8'h48
`define CRF_CH_L     8'h4C
`define CRF_CH_O     8'h4F
`define CRF_CH_C     8'h43
`define CRF_BCD_OVF  4'hF
// ==========================================================
// timing: clock and timebase share the 100 ns period
`define CRF_CLK_NS   100
`define CRF_TB_NS    100
`endif

// ---- logic/crf_pkg.sv ----
package crf_pkg;
  // record type letters
  typedef enum logic [3:0] {
    RT_FREQ = 4'h0, RT_TIME = 4'h1, RT_VOLT = 4'h2, RT_RATIO = 4'h3,
    RT_TOT_FINAL = 4'h4, RT_TOT_INTERIM = 4'h5, RT_TRIG_A = 4'h6,
    RT_TRIG_B = 4'h7, RT_PEAK_HI = 4'h8, RT_PEAK_LO = 4'h9,
    RT_OVER = 4'hA, RT_CAL = 4'hB
  } crf_rtype_t;
  // measurement function
  typedef enum logic [3:0] {
    FN_FREQ_A = 4'h0, FN_FREQ_B = 4'h1, FN_THIRD_CHANNEL_FREQUENCY = 4'h2, FN_PERIOD = 4'h3,
    FN_TI = 4'h4, FN_RATIO = 4'h5, FN_TOTAL = 4'h6, FN_OTHER = 4'h7
  } crf_func_t;
  // record kind held in the buffer
  typedef enum logic [2:0] {
    KD_NORMAL = 3'h0, KD_OVER = 3'h1, KD_PEAK = 3'h2, KD_CAL = 3'h3,
    KD_HS = 3'h4
  } crf_kind_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } crf_state_t;
endpackage : crf_pkg

// ---- tb/crf_formatter_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module crf_formatter_tb_top;
  localparam logic [43:0] MANT = 44'h45834126500;
  logic clk, reset_n, clk_en, gate_open, ext_arm_en, stop_arm, talk_only;
  logic event_a_in, event_b_in, event_c_in, timebase_in, meas_done, slow;
  logic fast_raw_output_on, fast_raw_output_off, cal_data_request;
  logic total_start_function, total_stop_function, out_ready;
  logic res_neg, res_exp_neg, res_zero, res_overflow, res_peak;
  logic out_valid, out_eoi_ff, busy;
  logic [7:0]          start_interp_count, stop_interp_count;
  logic [7:0]          res_exp, out_data_ff;
  logic [47:0]         cal_digits;
  logic [43:0]         res_mant;
  logic [3:0]          res_ndig;
  crf_pkg::crf_func_t  meas_func;
  crf_pkg::crf_rtype_t res_type;
  int                  n_mismatch = 0;
  int                  tests_run = 0;
  // =====
  // design and host
  crf_formatter dut_u (.clk, .reset_n, .clk_en, .event_a_in, .event_b_in,
    .event_c_in, .timebase_in, .gate_open, .meas_func, .start_interp_count,
    .stop_interp_count, .fast_raw_output_on, .fast_raw_output_off,
    .total_start_function, .total_stop_function, .ext_arm_en, .stop_arm,
    .talk_only, .cal_data_request, .cal_digits, .meas_done, .res_type,
    .res_neg, .res_mant, .res_ndig, .res_exp_neg, .res_exp, .res_zero,
    .res_overflow, .res_peak, .out_ready, .out_valid, .out_data_ff,
    .out_eoi_ff, .busy);
  crf_host_model host_u (.clk, .reset_n, .clk_en, .slow, .out_valid,
    .out_data_ff, .out_eoi_ff, .out_ready);
  // =====
  // shared checks
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  // bounded wait, then a few idle cycles to catch extra bytes
  task automatic drain(input logic [8:0] exp[$]);
    int i;
    i = 0;
    while (host_u.rx_q.size() < exp.size() && i < 300) begin
      @(negedge clk);
      i++;
    end
    repeat (4) @(negedge clk);
    chk({7'h00, busy, out_eoi_ff}, 9'h000);
    chk(9'(host_u.rx_q.size()), 9'(exp.size()));
    foreach (exp[k]) chk(host_u.rx_q[k], exp[k]);
    host_u.rx_q.delete();
  endtask : drain
  task automatic text(input string s);
    logic [8:0] q[$];
    foreach (s[k]) q.push_back({1'b0, s[k]});
    q.push_back(9'h00D);
    q.push_back(9'h00A);
    drain(q);
  endtask : text
  // flags: neg, exp neg, zero, overflow, peak
  task automatic send(input crf_pkg::crf_rtype_t t, input logic [43:0] m,
                      input logic [3:0] n, input logic [7:0] e,
                      input logic [4:0] f);
    res_type = t;
    res_mant = m;
    res_ndig = n;
    res_exp = e;
    {res_neg, res_exp_neg, res_zero, res_overflow, res_peak} = f;
    pulse(meas_done);
  endtask : send
  // pins in order timebase, c, b, a
  task automatic burst(input logic [3:0] pins, input int n);
    for (int i = 0; i < n; i++) begin
      {timebase_in, event_c_in, event_b_in, event_a_in} = pins;
      repeat (3) @(negedge clk);
      {timebase_in, event_c_in, event_b_in, event_a_in} = 4'h0;
      repeat (3) @(negedge clk);
    end
  endtask : burst
  task automatic gate_run(input logic [3:0] p1, input int n1,
                          input logic [3:0] p2, input int n2);
    gate_open = 1'b1;
    repeat (6) @(negedge clk);
    burst(p1, n1);
    burst(p2, n2);
    repeat (4) @(negedge clk);
    gate_open = 1'b0;
  endtask : gate_run
  // =====
  // scenarios
  task automatic t_ascii();
    string l;
    l = "FSVRTtABHL";
    slow = 1'b1;
    for (int i = 0; i < 10; i++) begin
      send(crf_pkg::crf_rtype_t'(i), MANT, 4'h9, 8'h05, 5'h00);
      text({l.substr(i, i), "   +4.58341265E+05"});
    end
    slow = 1'b0;
    send(crf_pkg::RT_TIME, 44'h50000000000, 4'h1, 8'h03, 5'h18);
    text("S            -5E-03");
    send(crf_pkg::RT_VOLT, 44'h0, 4'h1, 8'h00, 5'h04);
    text("V             0E+00");
    send(crf_pkg::RT_FREQ, MANT, 4'h9, 8'h05, 5'h02);
    text("O +9.9999999999E+99");
    send(crf_pkg::RT_PEAK_HI, MANT, 4'h9, 8'h05, 5'h03);
    text("O+9999999,O+9999999");
    send(crf_pkg::RT_TRIG_A, MANT, 4'h9, 8'h05, 5'h02);
    text("A   +4.58341265E+05");
    cal_digits = 48'h123456789012;
    pulse(cal_data_request);
    text("C 123,456,789,012");
  endtask : t_ascii
  task automatic t_fast();
    meas_func = crf_pkg::FN_FREQ_A;
    start_interp_count = 8'h3C;
    stop_interp_count = 8'hA5;
    pulse(fast_raw_output_on);
    // other channels toggle too; only channel a may count
    gate_run(4'hF, 3, 4'hE, 2);
    drain('{9'h000, 9'h000, 9'h003, 9'h000, 9'h000, 9'h005, 9'h03C,
            9'h1A5});
    meas_func = crf_pkg::FN_THIRD_CHANNEL_FREQUENCY;
    gate_run(4'hC, 20, 4'hC, 1);
    drain('{9'h000, 9'h000, 9'h001, 9'h000, 9'h000, 9'h021, 9'h03C,
            9'h1A5});
    meas_func = crf_pkg::FN_RATIO;
    gate_run(4'h3, 2, 4'h9, 3);
    drain('{9'h000, 9'h000, 9'h002, 9'h000, 9'h000, 9'h005, 9'h03C,
            9'h1A5});
    send(crf_pkg::RT_RATIO, MANT, 4'h9, 8'h05, 5'h00);
    repeat (30) @(negedge clk);
    chk(9'(host_u.rx_q.size()), 9'h000);
    meas_func = crf_pkg::FN_OTHER;
    gate_run(4'h0, 1, 4'h0, 1);
    send(crf_pkg::RT_VOLT, MANT, 4'h9, 8'h05, 5'h00);
    text("V   +4.58341265E+05");
    chk(9'(host_u.corr_num(60 - 66)), 9'h0FA);
    pulse(fast_raw_output_off);
  endtask : t_fast
  task automatic t_total();
    meas_func = crf_pkg::FN_TOTAL;
    talk_only = 1'b1;
    pulse(total_start_function);
    send(crf_pkg::RT_TOT_INTERIM, MANT, 4'h9, 8'h05, 5'h00);
    repeat (30) @(negedge clk);
    chk(9'(host_u.rx_q.size()), 9'h000);
    pulse(total_stop_function);
    text("T   +4.58341265E+05");
    talk_only = 1'b0;
    // stopped: events and results are both ignored
    burst(4'h1, 2);
    send(crf_pkg::RT_TOT_INTERIM, MANT, 4'h9, 8'h05, 5'h00);
    repeat (30) @(negedge clk);
    chk(9'(host_u.rx_q.size()), 9'h000);
    pulse(total_start_function);
    send(crf_pkg::RT_TOT_INTERIM, MANT, 4'h9, 8'h05, 5'h00);
    text("t   +4.58341265E+05");
    ext_arm_en = 1'b1;
    pulse(total_stop_function);
    send(crf_pkg::RT_TOT_INTERIM, MANT, 4'h9, 8'h05, 5'h00);
    text("t   +4.58341265E+05");
    pulse(stop_arm);
    text("T   +4.58341265E+05");
    ext_arm_en = 1'b0;
  endtask : t_total
  task automatic summarize();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  // =====
  // clock, reset, sequence, watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {reset_n, gate_open, ext_arm_en, stop_arm, talk_only, meas_done} = '0;
    {event_a_in, event_b_in, event_c_in, timebase_in, slow} = '0;
    {fast_raw_output_on, fast_raw_output_off, cal_data_request} = '0;
    {total_start_function, total_stop_function} = '0;
    {res_neg, res_exp_neg, res_zero, res_overflow, res_peak} = '0;
    {start_interp_count, stop_interp_count, res_exp} = '0;
    {cal_digits, res_mant, res_ndig} = '0;
    clk_en = 1'b1;
    meas_func = crf_pkg::FN_FREQ_A;
    res_type = crf_pkg::RT_FREQ;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    t_ascii();
    t_fast();
    t_total();
    summarize();
  end
  // full run is well under 3000 cycles
  initial begin
    #800000;
    n_mismatch++;
    summarize();
  end
endmodule : crf_formatter_tb_top
`default_nettype wire

// ---- tb/crf_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module crf_host_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       slow,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data_ff,
  input  wire logic       out_eoi_ff,
  output logic            out_ready
);
  logic [8:0] rx_q[$];
  logic       tog_ff;
  // =====
  // sink pacing: slow stalls every other cycle
  always_ff @(negedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tog_ff <= 1'b0;
    end else begin
      tog_ff <= ~tog_ff;
    end
  end
  assign out_ready = ~slow | tog_ff;
  // =====
  // capture taken bytes with the end flag on top
  always @(posedge clk) begin
    if (reset_n && clk_en && out_valid && out_ready) begin
      rx_q.push_back({out_eoi_ff, out_data_ff});
    end
  end
  // =====
  // controller folds short negative numerators
  function automatic int corr_num(input int num);
    return (num <= -5 && num >= -256) ? num + 256 : num;
  endfunction : corr_num
endmodule : crf_host_model
`default_nettype wire
